// ### logic/omx_ctrl.sv
// output mux, output sync and fractional divider power control registers
// Functional notes
// - sync bit rising holds every output divider in reset while it stays set
// - sync bit falling releases all dividers together in one cycle
// - release from hold clears the output skew adjustment to zero
// - outputs 10 and 11 take divider J at 0, divider I at 1; reset 0
// - outputs 8 and 9 take divider I at 0, divider J at 1; reset 0
// - output 7 takes fractional H at 0, G at 1; reset 0
// - output 6 takes fractional G at 0, H at 1; reset 0
// - output 5 takes fractional F at 0, E at 1; reset 0
// - output 4 takes fractional E at 0, F at 1; reset 0
// - output 3 takes fractional D at 0, A at 1; reset 0
// - output 2 takes fractional C at 0, A at 1; reset 0
// - output 1 takes fractional B at 0, A at 1; reset 0
// - one power-down bit per fractional divider A..H, 1 powers it down, reset 0
// - reserved bits written as zero by software; they read back as zero
// - selectors and sync bit are read/write and reset to zero
// - new fine phase values reach dividers only after a sync bit toggle
`timescale 1ns/1ns
`include "omx_regs.svh"

module omx_ctrl
  import omx_pkg::*;
(
  input  wire logic         clock,          // configuration clock, 100 MHz
  input  wire logic         reset,          // synchronous, active high
  input  wire omx_cfg_req_t cfg_req,        // byte access from the serial engine
  output logic [7:0]        cfg_rdata,      // read data, one cycle after cfg_req.rd
  output logic              cfg_rvalid,     // read data valid pulse
  input  wire logic [7:0]   frac_div_in,    // fractional divider outputs, bit 0 = A
  input  wire logic [1:0]   int_div_in,     // integer divider outputs, bit 0 = I, bit 1 = J
  input  wire logic [31:0]  fine_phase_in,  // staged fine phase, 4 bits per divider, A lowest
  output logic [11:1]       out_q,          // selected clock for outputs 1..11
  output logic              div_hold,       // holds every output divider in reset
  output logic              skew_clear,     // one-cycle pulse: skew adjustment to zero
  output logic [31:0]       fine_phase,     // fine phase applied to dividers A..H
  output logic [7:0]        frac_pwr_down   // power-down per fractional divider, bit 0 = A
);

  // source table for outputs 1..7: index at select 0 and select 1 (A=0 .. H=7)
  // two small tables instead of seven case statements, so a swapped pair is easy to spot
  localparam logic [2:0] SRC0 [1:7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [2:0] SRC1 [1:7] = '{3'h0, 3'h0, 3'h0, 3'h5, 3'h4, 3'h7, 3'h6};

  omx_state_t state_reg;
  omx_state_t state_next;

  // address decode shared by the write and read paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // fractional source gated by its own power-down bit so a dead divider never toggles
  function automatic logic frac_pick(input logic [7:0] src, input logic [7:0] pwr, input logic [2:0] idx);
    frac_pick = src[idx] & ~pwr[idx];
  endfunction : frac_pick

  // next-state logic
  always_comb begin
    logic [7:0] rd_byte;
    logic       sel;
    rd_byte    = 8'h00;
    sel        = 1'b0;
    state_next = state_reg;
    state_next.skew_clear = 1'b0;
    state_next.rvalid     = 1'b0;

    // register writes; reserved bits are masked off, so they read back zero
    if (cfg_req.wr) begin
      if (hit(cfg_req.addr, `OMX_OFS_SYNC_CTRL))
        state_next.sync_hold = cfg_req.wdata[`OMX_BIT_SYNC_HOLD];
      if (hit(cfg_req.addr, `OMX_OFS_INT_ROUTE))
        state_next.int_route = cfg_req.wdata & `OMX_MASK_INT_ROUTE;
      if (hit(cfg_req.addr, `OMX_OFS_FRAC_ROUTE))
        state_next.frac_route = cfg_req.wdata & `OMX_MASK_FRAC_ROUTE;
      if (hit(cfg_req.addr, `OMX_OFS_PWR_DOWN))
        state_next.frac_pwr = cfg_req.wdata & `OMX_MASK_PWR_DOWN;
    end

    // edge detection against the remembered value; rewriting the same value does nothing
    state_next.sync_prev = state_reg.sync_hold;
    if (state_reg.sync_hold && !state_reg.sync_prev)
      state_next.div_hold = 1'b1;
    if (!state_reg.sync_hold && state_reg.sync_prev) begin
      state_next.div_hold   = 1'b0;
      state_next.skew_clear = 1'b1;
      state_next.fine_phase = fine_phase_in;
    end

    // output routing; held dividers give static outputs
    for (int i = 1; i <= 7; i++) begin
      sel = state_reg.frac_route[i];
      state_next.out_q[i] = ~state_reg.div_hold &
        frac_pick(frac_div_in, state_reg.frac_pwr, sel ? SRC1[i] : SRC0[i]);
    end
    state_next.out_q[8]  = ~state_reg.div_hold &
      (state_reg.int_route[`OMX_BIT_MUX_8_9] ? int_div_in[1] : int_div_in[0]);
    state_next.out_q[9]  = state_next.out_q[8];
    state_next.out_q[10] = ~state_reg.div_hold &
      (state_reg.int_route[`OMX_BIT_MUX_10_11] ? int_div_in[0] : int_div_in[1]);
    state_next.out_q[11] = state_next.out_q[10];

    // read path; unmapped and reserved addresses read zero
    // data comes from the registers before this cycle's write lands
    if (hit(cfg_req.addr, `OMX_OFS_SYNC_CTRL))
      rd_byte = {7'h00, state_reg.sync_hold};
    else if (hit(cfg_req.addr, `OMX_OFS_INT_ROUTE))
      rd_byte = state_reg.int_route;
    else if (hit(cfg_req.addr, `OMX_OFS_FRAC_ROUTE))
      rd_byte = state_reg.frac_route;
    else if (hit(cfg_req.addr, `OMX_OFS_PWR_DOWN))
      rd_byte = state_reg.frac_pwr;
    if (cfg_req.rd) begin
      state_next.rdata  = rd_byte;
      state_next.rvalid = 1'b1;
    end
  end

  // state register; everything powers up at zero except the applied fine phase
  // fine phase starts at four sixteenths so the dividers line up before any sync
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg            <= '0;
      state_reg.sync_hold  <= 1'(`OMX_RST_SYNC_CTRL >> `OMX_BIT_SYNC_HOLD);
      state_reg.int_route  <= `OMX_RST_INT_ROUTE;
      state_reg.frac_route <= `OMX_RST_FRAC_ROUTE;
      state_reg.frac_pwr   <= `OMX_RST_PWR_DOWN;
      state_reg.fine_phase <= `OMX_RST_FINE;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flip-flops
  // limitation: out_q lags its divider by one clock, a sampled copy of the source
  assign cfg_rdata     = state_reg.rdata;
  assign cfg_rvalid    = state_reg.rvalid;
  assign out_q         = state_reg.out_q;
  assign div_hold      = state_reg.div_hold;
  assign skew_clear    = state_reg.skew_clear;
  assign fine_phase    = state_reg.fine_phase;
  assign frac_pwr_down = state_reg.frac_pwr;

  // checks next to the logic they guard
  a_hold_on_rise: assert property (@(posedge clock) disable iff (reset)
    $rose(state_reg.sync_hold) |=> div_hold)
    else $error("divider hold not raised after sync bit rose");

  a_hold_persists: assert property (@(posedge clock) disable iff (reset)
    div_hold && state_reg.sync_hold && state_reg.sync_prev |=> div_hold)
    else $error("divider hold dropped while sync bit set");

  a_release_fall: assert property (@(posedge clock) disable iff (reset)
    $fell(state_reg.sync_hold) |=> !div_hold && skew_clear)
    else $error("release or skew clear missing after sync bit fell");

  a_skew_pulse: assert property (@(posedge clock) disable iff (reset)
    skew_clear |=> !skew_clear)
    else $error("skew clear longer than one cycle");

  a_fine_load: assert property (@(posedge clock) disable iff (reset)
    !skew_clear |-> $stable(fine_phase) or $past(reset))
    else $error("fine phase changed without a sync release");

  a_held_static: assert property (@(posedge clock) disable iff (reset)
    div_hold |=> out_q == 11'h000)
    else $error("output toggled while dividers held");

  a_pwr_static: assert property (@(posedge clock) disable iff (reset)
    !div_hold && state_reg.frac_pwr[7] && !state_reg.frac_route[7] |=> !out_q[7])
    else $error("output 7 passed a powered-down divider");

  a_route_out1: assert property (@(posedge clock) disable iff (reset)
    !div_hold && state_reg.frac_route[1] && !state_reg.frac_pwr[0] |=> out_q[1] == $past(frac_div_in[0]))
    else $error("output 1 not routed from divider A");

  a_route_int: assert property (@(posedge clock) disable iff (reset)
    !div_hold && !state_reg.int_route[1] |=> out_q[10] == $past(int_div_in[1]) && out_q[11] == out_q[10])
    else $error("outputs 10 and 11 not routed from divider J");

  a_read_back: assert property (@(posedge clock) disable iff (reset)
    cfg_req.rd && cfg_req.addr == `OMX_OFS_SYNC_CTRL |=> cfg_rvalid && cfg_rdata[7:1] == 7'h00)
    else $error("sync register read back wrong");

  // fractional selectors, both settings for outputs 2..7 and select 0 for output 1, with the chosen divider running
  a_route1_sel0: assert property (@(posedge clock) disable iff (reset)
    !div_hold && !state_reg.frac_route[1] && !state_reg.frac_pwr[1] |=> out_q[1] == $past(frac_div_in[1]))
    else $error("output 1 not routed from divider B");

  a_route2_sel0: assert property (@(posedge clock) disable iff (reset)
    !div_hold && !state_reg.frac_route[2] && !state_reg.frac_pwr[2] |=> out_q[2] == $past(frac_div_in[2]))
    else $error("output 2 not routed from divider C");

  a_route2_sel1: assert property (@(posedge clock) disable iff (reset)
    !div_hold && state_reg.frac_route[2] && !state_reg.frac_pwr[0] |=> out_q[2] == $past(frac_div_in[0]))
    else $error("output 2 not routed from divider A");

  a_route3_sel0: assert property (@(posedge clock) disable iff (reset)
    !div_hold && !state_reg.frac_route[3] && !state_reg.frac_pwr[3] |=> out_q[3] == $past(frac_div_in[3]))
    else $error("output 3 not routed from divider D");

  a_route3_sel1: assert property (@(posedge clock) disable iff (reset)
    !div_hold && state_reg.frac_route[3] && !state_reg.frac_pwr[0] |=> out_q[3] == $past(frac_div_in[0]))
    else $error("output 3 not routed from divider A");

  a_route4_sel0: assert property (@(posedge clock) disable iff (reset)
    !div_hold && !state_reg.frac_route[4] && !state_reg.frac_pwr[4] |=> out_q[4] == $past(frac_div_in[4]))
    else $error("output 4 not routed from divider E");

  a_route4_sel1: assert property (@(posedge clock) disable iff (reset)
    !div_hold && state_reg.frac_route[4] && !state_reg.frac_pwr[5] |=> out_q[4] == $past(frac_div_in[5]))
    else $error("output 4 not routed from divider F");

  a_route5_sel0: assert property (@(posedge clock) disable iff (reset)
    !div_hold && !state_reg.frac_route[5] && !state_reg.frac_pwr[5] |=> out_q[5] == $past(frac_div_in[5]))
    else $error("output 5 not routed from divider F");

  a_route5_sel1: assert property (@(posedge clock) disable iff (reset)
    !div_hold && state_reg.frac_route[5] && !state_reg.frac_pwr[4] |=> out_q[5] == $past(frac_div_in[4]))
    else $error("output 5 not routed from divider E");

  a_route6_sel0: assert property (@(posedge clock) disable iff (reset)
    !div_hold && !state_reg.frac_route[6] && !state_reg.frac_pwr[6] |=> out_q[6] == $past(frac_div_in[6]))
    else $error("output 6 not routed from divider G");

  a_route6_sel1: assert property (@(posedge clock) disable iff (reset)
    !div_hold && state_reg.frac_route[6] && !state_reg.frac_pwr[7] |=> out_q[6] == $past(frac_div_in[7]))
    else $error("output 6 not routed from divider H");

  a_route7_sel0: assert property (@(posedge clock) disable iff (reset)
    !div_hold && !state_reg.frac_route[7] && !state_reg.frac_pwr[7] |=> out_q[7] == $past(frac_div_in[7]))
    else $error("output 7 not routed from divider H");

  a_route7_sel1: assert property (@(posedge clock) disable iff (reset)
    !div_hold && state_reg.frac_route[7] && !state_reg.frac_pwr[6] |=> out_q[7] == $past(frac_div_in[6]))
    else $error("output 7 not routed from divider G");

  // integer selectors
  a_route8_sel0: assert property (@(posedge clock) disable iff (reset)
    !div_hold && !state_reg.int_route[0] |=> out_q[8] == $past(int_div_in[0]) && out_q[9] == out_q[8])
    else $error("outputs 8 and 9 not routed from divider I");

  a_route8_sel1: assert property (@(posedge clock) disable iff (reset)
    !div_hold && state_reg.int_route[0] |=> out_q[8] == $past(int_div_in[1]) && out_q[9] == out_q[8])
    else $error("outputs 8 and 9 not routed from divider J");

  a_route10_sel1: assert property (@(posedge clock) disable iff (reset)
    !div_hold && state_reg.int_route[1] |=> out_q[10] == $past(int_div_in[0]) && out_q[11] == out_q[10])
    else $error("outputs 10 and 11 not routed from divider I");

  // a selected divider that is powered down gives a quiet output
  a_pwr_out1: assert property (@(posedge clock) disable iff (reset)
    state_reg.frac_route[1] && state_reg.frac_pwr[0] |=> !out_q[1])
    else $error("output 1 passed a powered-down divider");

  a_pwr_out2: assert property (@(posedge clock) disable iff (reset)
    !state_reg.frac_route[2] && state_reg.frac_pwr[2] |=> !out_q[2])
    else $error("output 2 passed a powered-down divider");

  a_pwr_out4: assert property (@(posedge clock) disable iff (reset)
    !state_reg.frac_route[4] && state_reg.frac_pwr[4] |=> !out_q[4])
    else $error("output 4 passed a powered-down divider");

  a_pwr_out6: assert property (@(posedge clock) disable iff (reset)
    state_reg.frac_route[6] && state_reg.frac_pwr[7] |=> !out_q[6])
    else $error("output 6 passed a powered-down divider");

  // register writes land one edge after the strobe
  a_sync_write: assert property (@(posedge clock) disable iff (reset)
    cfg_req.wr && cfg_req.addr == `OMX_OFS_SYNC_CTRL |=> state_reg.sync_hold == $past(cfg_req.wdata[0]))
    else $error("sync bit write lost");

  a_int_write: assert property (@(posedge clock) disable iff (reset)
    cfg_req.wr && cfg_req.addr == `OMX_OFS_INT_ROUTE |=>
      state_reg.int_route == ($past(cfg_req.wdata) & `OMX_MASK_INT_ROUTE))
    else $error("integer route write lost");

  a_frac_write: assert property (@(posedge clock) disable iff (reset)
    cfg_req.wr && cfg_req.addr == `OMX_OFS_FRAC_ROUTE |=>
      state_reg.frac_route == ($past(cfg_req.wdata) & `OMX_MASK_FRAC_ROUTE))
    else $error("fractional route write lost");

  a_pwr_write: assert property (@(posedge clock) disable iff (reset)
    cfg_req.wr && cfg_req.addr == `OMX_OFS_PWR_DOWN |=> frac_pwr_down == $past(cfg_req.wdata))
    else $error("power-down write lost");

  // read answers
  a_rsvd_read: assert property (@(posedge clock) disable iff (reset)
    cfg_req.rd && cfg_req.addr == `OMX_OFS_PWR_RSVD |=> cfg_rvalid && cfg_rdata == 8'h00)
    else $error("reserved register read not zero");

  a_read_sync: assert property (@(posedge clock) disable iff (reset)
    cfg_req.rd && cfg_req.addr == `OMX_OFS_SYNC_CTRL |=> cfg_rdata[0] == $past(state_reg.sync_hold))
    else $error("sync bit read back wrong");

  a_read_int: assert property (@(posedge clock) disable iff (reset)
    cfg_req.rd && cfg_req.addr == `OMX_OFS_INT_ROUTE |=> cfg_rdata == $past(state_reg.int_route))
    else $error("integer route read back wrong");

  a_read_frac: assert property (@(posedge clock) disable iff (reset)
    cfg_req.rd && cfg_req.addr == `OMX_OFS_FRAC_ROUTE |=> cfg_rdata == $past(state_reg.frac_route))
    else $error("fractional route read back wrong");

  a_read_pwr: assert property (@(posedge clock) disable iff (reset)
    cfg_req.rd && cfg_req.addr == `OMX_OFS_PWR_DOWN |=> cfg_rdata == $past(frac_pwr_down))
    else $error("power-down read back wrong");

  a_rvalid_cause: assert property (@(posedge clock) disable iff (reset)
    cfg_rvalid |-> $past(cfg_req.rd))
    else $error("read valid without a read strobe");

  a_rdata_hold: assert property (@(posedge clock) disable iff (reset)
    !cfg_rvalid |-> $stable(cfg_rdata))
    else $error("read data moved without a read");

  // sync sequencing
  a_no_repeat: assert property (@(posedge clock) disable iff (reset)
    state_reg.sync_hold == state_reg.sync_prev |=> $stable(div_hold))
    else $error("divider hold moved without a sync change");

  a_hold_level: assert property (@(posedge clock) disable iff (reset)
    state_reg.sync_hold && state_reg.sync_prev |-> div_hold)
    else $error("dividers free while sync bit settled high");

  a_idle_free: assert property (@(posedge clock) disable iff (reset)
    !state_reg.sync_hold && !state_reg.sync_prev |-> !div_hold)
    else $error("dividers held while sync bit settled low");

  a_fine_value: assert property (@(posedge clock) disable iff (reset)
    skew_clear |-> fine_phase == $past(fine_phase_in))
    else $error("fine phase not taken at release");

  a_skew_cause: assert property (@(posedge clock) disable iff (reset)
    skew_clear |-> $past(state_reg.sync_prev) && !$past(state_reg.sync_hold))
    else $error("skew clear without a sync release");

  // covers for the main scenarios
  c_sync_cycle: cover property (@(posedge clock) disable iff (reset) $rose(div_hold) ##[1:50] skew_clear);
  c_pwr_down:   cover property (@(posedge clock) disable iff (reset) frac_pwr_down == 8'hff);
  c_route_alt:  cover property (@(posedge clock) disable iff (reset) state_reg.frac_route == 8'hfe);
  c_sync_again: cover property (@(posedge clock) disable iff (reset)
    state_reg.sync_hold && cfg_req.wr && cfg_req.addr == `OMX_OFS_SYNC_CTRL && cfg_req.wdata[0]);
  c_int_swap:   cover property (@(posedge clock) disable iff (reset) state_reg.int_route == 8'h03);

endmodule : omx_ctrl

// ### logic/omx_pkg.sv
// types shared by the output mux, sync and power block
package omx_pkg;

  // byte access from the serial configuration engine
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } omx_cfg_req_t;

  // complete state of the block
  typedef struct packed {
    logic        sync_hold;
    logic        sync_prev;
    logic [7:0]  int_route;
    logic [7:0]  frac_route;
    logic [7:0]  frac_pwr;
    logic        div_hold;
    logic        skew_clear;
    logic [31:0] fine_phase;
    logic [11:1] out_q;
    logic [7:0]  rdata;
    logic        rvalid;
  } omx_state_t;

endpackage : omx_pkg

// ### logic/omx_regs.svh
// register offsets, field positions and reset values of the output mux, sync and power block
`ifndef OMX_REGS_SVH
`define OMX_REGS_SVH

// register offsets on the configuration port
`define OMX_OFS_SYNC_CTRL   16'h008d
`define OMX_OFS_INT_ROUTE   16'h008e
`define OMX_OFS_FRAC_ROUTE  16'h008f
`define OMX_OFS_PWR_RSVD    16'h0090
`define OMX_OFS_PWR_DOWN    16'h0091

// field positions
`define OMX_BIT_SYNC_HOLD   0
`define OMX_BIT_MUX_8_9     0
`define OMX_BIT_MUX_10_11   1
`define OMX_BIT_MUX_FIRST   1
`define OMX_BIT_MUX_LAST    7

// writable masks; every other bit is reserved
`define OMX_MASK_SYNC_CTRL  8'h01
`define OMX_MASK_INT_ROUTE  8'h03
`define OMX_MASK_FRAC_ROUTE 8'hfe
`define OMX_MASK_PWR_DOWN   8'hff

// reset values
`define OMX_RST_SYNC_CTRL   8'h00
`define OMX_RST_INT_ROUTE   8'h00
`define OMX_RST_FRAC_ROUTE  8'h00
`define OMX_RST_PWR_DOWN    8'h00
`define OMX_RST_FINE        32'h4444_4444

`endif

// ### tb/omx_ctrl_bench.sv
// self-checking bench for the output mux, sync and power control block
`timescale 1ns/1ns
module omx_ctrl_bench;
  import omx_pkg::*;
  logic         clock         = 1'b0;
  logic         reset         = 1'b1;
  omx_cfg_req_t cfg_req       = '0;
  logic [7:0]   frac_div_in   = 8'h00;
  logic [1:0]   int_div_in    = 2'h0;
  logic [31:0]  fine_phase_in = 32'h0000_0000;
  logic [7:0]   cfg_rdata;
  logic         cfg_rvalid;
  logic [11:1]  out_q;
  logic         div_hold;
  logic         skew_clear;
  logic [31:0]  fine_phase;
  logic [7:0]   frac_pwr_down;
  int           bad_count     = 0;
  int           num_checks    = 0;
  int           cycles        = 0;
  // address, written byte, byte expected back
  logic [15:0]  ra [6] = '{16'h008d, 16'h008e, 16'h008f, 16'h0091, 16'h0090, 16'h0012};
  // reserved bits are always written as zero
  logic [7:0]   rw [6] = '{8'h00, 8'h02, 8'hfe, 8'ha5, 8'h00, 8'hff};
  logic [7:0]   rx [6] = '{8'h00, 8'h02, 8'hfe, 8'ha5, 8'h00, 8'h00};
  logic [7:0]   rt [4] = '{8'h00, 8'hfe, 8'haa, 8'h54};
  logic [7:0]   pt [4] = '{8'hff, 8'h8f, 8'hf0, 8'h3c};
  logic [7:0]   ft [4] = '{8'hff, 8'hff, 8'ha5, 8'hff};

  omx_ctrl dut (.clock(clock), .reset(reset), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .frac_div_in(frac_div_in), .int_div_in(int_div_in),
    .fine_phase_in(fine_phase_in), .out_q(out_q), .div_hold(div_hold), .skew_clear(skew_clear),
    .fine_phase(fine_phase), .frac_pwr_down(frac_pwr_down));

  always #5 clock = ~clock;

  // hang guard: the whole sequence needs well under 300 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [15:0] addr, input logic [7:0] data);
    cfg_req.addr = addr;
    cfg_req.wdata = data;
    cfg_req.wr = 1'b1;
    tick(1);
    cfg_req.wr = 1'b0;
    tick(1);
  endtask : wr_reg

  // read answer is registered, so it is seen one edge after the strobe; an idle edge follows
  task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp);
    cfg_req.addr = addr;
    cfg_req.rd = 1'b1;
    tick(1);
    cfg_req.rd = 1'b0;
    chk("read valid", 32'h1, {31'h0, cfg_rvalid});
    chk("read data", {24'h0, exp}, {24'h0, cfg_rdata});
    tick(1);
  endtask : rd_chk

  // selection index per fractional output, bit 0 = divider A
  function automatic logic [11:1] exp_out(input logic [7:0] fr, input logic [7:0] ir, input logic [7:0] pd,
                                          input logic [7:0] fi, input logic [1:0] ii);
    logic [2:0]  s [1:7];
    logic [11:1] q;
    s[1] = fr[1] ? 3'h0 : 3'h1;
    s[2] = fr[2] ? 3'h0 : 3'h2;
    s[3] = fr[3] ? 3'h0 : 3'h3;
    s[4] = fr[4] ? 3'h5 : 3'h4;
    s[5] = fr[5] ? 3'h4 : 3'h5;
    s[6] = fr[6] ? 3'h7 : 3'h6;
    s[7] = fr[7] ? 3'h6 : 3'h7;
    for (int n = 1; n <= 7; n++) q[n] = fi[s[n]] & ~pd[s[n]];
    q[8] = ir[0] ? ii[1] : ii[0];
    q[9] = q[8];
    q[10] = ir[1] ? ii[0] : ii[1];
    q[11] = q[10];
    return q;
  endfunction : exp_out

  initial begin
    tick(8);
    reset = 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(ra[i], 8'h00);
    chk("fine phase", 32'h4444_4444, fine_phase);
    $display("test reset values done");
    // writable fields, reserved bits, reserved and unmapped places
    for (int i = 0; i < 6; i++) wr_reg(ra[i], rw[i]);
    for (int i = 0; i < 6; i++) rd_chk(ra[i], rx[i]);
    chk("power down", 32'ha5, {24'h0, frac_pwr_down});
    chk("hold", 32'h0, {31'h0, div_hold});
    $display("test register access done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(16'h008f, rt[i]);
      wr_reg(16'h008e, 8'(i));
      wr_reg(16'h0091, pt[i]);
      frac_div_in = ft[i];
      int_div_in = ~2'(i);
      tick(2);
      chk("route", {21'h0, exp_out(rt[i], 8'(i), pt[i], ft[i], ~2'(i))}, {21'h0, out_q});
    end
    $display("test routing and power down done");
    // outputs would be all ones without the hold
    wr_reg(16'h0091, 8'h00);
    int_div_in = 2'h3;
    fine_phase_in = 32'h1234_abcd;
    wr_reg(16'h008d, 8'h01);
    chk("hold on", 32'h1, {31'h0, div_hold});
    tick(1);
    chk("held outputs", 32'h0, {21'h0, out_q});
    chk("fine before release", 32'h4444_4444, fine_phase);
    wr_reg(16'h008d, 8'h01);
    tick(1);
    chk("no repeat action", 32'h2, {30'h0, div_hold, skew_clear});
    wr_reg(16'h008d, 8'h00);
    chk("release", 32'h1, {30'h0, div_hold, skew_clear});
    chk("fine after release", 32'h1234_abcd, fine_phase);
    tick(1);
    chk("skew pulse end", 32'h0, {31'h0, skew_clear});
    chk("outputs run", {21'h0, 11'h7ff}, {21'h0, out_q});
    $display("test output sync done");
    give_verdict();
  end
endmodule : omx_ctrl_bench
